// ===== design/pdr_dir_reg.sv
module pdr_dir_reg
  import pdr_pkg::*;
#(
  parameter logic [7:0] IMPL_MASK = 8'hFF
)
(
  input  wire logic       mclk,     // System clock
  input  wire logic       reset,    // Synchronous reset, active high
  input  wire logic       sel,      // This register is addressed
  input  wire logic       byte_wr,  // Whole-byte write
  input  wire logic       bit_wr,   // Single-bit write
  input  wire logic [2:0] bit_sel,  // Bit position
  input  wire logic       bit_val,  // Bit value
  input  wire logic [7:0] wdata,    // Byte data
  output logic      [7:0] dir_reg,  // Direction bits, 1 = input
  output logic      [7:0] buf_reg   // Output buffer enables, 1 = driving
);

  logic [7:0] dir_next;
  logic [7:0] raw_next;

  // write merge, ones forced
  // Merge byte or bit write; unimplemented bits forced high
  always_comb
  begin
    raw_next = dir_reg;
    if (sel && byte_wr)
    begin
      raw_next = wdata;
    end
    else if (sel && bit_wr)
    begin
      raw_next[bit_sel] = bit_val;
    end
    dir_next = raw_next | ~IMPL_MASK;
  end

  // reset all ones
  // Direction storage; reset leaves every pin an input
  always_ff @(posedge mclk)
  begin
    if (reset)
      dir_reg <= PDR_RESET_VAL;
    else
      dir_reg <= dir_next;
  end

  // buffer on when clear
  // Buffer enable kept in its own flop so the pin driver sees no gate
  always_ff @(posedge mclk)
  begin
    if (reset)
      buf_reg <= ~PDR_RESET_VAL;
    else
      buf_reg <= ~dir_next;
  end

endmodule : pdr_dir_reg

// ===== design/pdr_pkg.sv
package pdr_pkg;

  // Register count and widths
  localparam int          PDR_NREG      = 10;
  localparam int          PDR_IDX_W     = 4;
  localparam logic [3:0]  PDR_IDX_NONE  = 4'hF;
  localparam logic [7:0]  PDR_RESET_VAL = 8'hFF;
  localparam logic [7:0]  PDR_UNMAPPED  = 8'hFF;

  // Byte addresses of the direction registers
  localparam logic [15:0] PDR_OFS_P1  = 16'hFF21;
  localparam logic [15:0] PDR_OFS_P2  = 16'hFF22;
  localparam logic [15:0] PDR_OFS_P3  = 16'hFF23;
  localparam logic [15:0] PDR_OFS_P4  = 16'hFF24;
  localparam logic [15:0] PDR_OFS_P8  = 16'hFF28;
  localparam logic [15:0] PDR_OFS_P10 = 16'hFF2A;
  localparam logic [15:0] PDR_OFS_P11 = 16'hFF2B;
  localparam logic [15:0] PDR_OFS_P12 = 16'hFF2C;
  localparam logic [15:0] PDR_OFS_P14 = 16'hFF2E;
  localparam logic [15:0] PDR_OFS_P15 = 16'hFF2F;

  // Register index of port 8, the one only the larger variant has
  localparam logic [3:0]  PDR_IDX_P8 = 4'h4;

  // Implemented-bit masks, smaller variant (index order as above)
  localparam logic [PDR_NREG-1:0][7:0] PDR_MASK_SMALL = {
    8'h0F, 8'h0F, 8'h01, 8'h0C, 8'h03, 8'h00, 8'h01, 8'h1E, 8'h3F, 8'h0C};

  // Implemented-bit masks, larger variant
  localparam logic [PDR_NREG-1:0][7:0] PDR_MASK_LARGE = {
    8'h0F, 8'h0F, 8'h01, 8'h0E, 8'h03, 8'h01, 8'h03, 8'h1E, 8'h3F, 8'h0E};

  // One processor access to the register space
  typedef struct packed {
    logic        rd;       // Byte read
    logic        byte_wr;  // Whole-byte write
    logic        bit_wr;   // Single-bit write
    logic [2:0]  bit_sel;  // Bit position for bit_wr
    logic        bit_val;  // Value for bit_wr
    logic [15:0] addr;     // Byte address
    logic [7:0]  wdata;    // Data for byte_wr
  } pdr_req_t;

  // Address decode to register index
  function automatic logic [3:0] pdr_index(input logic [15:0] addr);
    logic [3:0] idx;
    idx = PDR_IDX_NONE;
    case (addr)
      PDR_OFS_P1:  idx = 4'h0;
      PDR_OFS_P2:  idx = 4'h1;
      PDR_OFS_P3:  idx = 4'h2;
      PDR_OFS_P4:  idx = 4'h3;
      PDR_OFS_P8:  idx = PDR_IDX_P8;
      PDR_OFS_P10: idx = 4'h5;
      PDR_OFS_P11: idx = 4'h6;
      PDR_OFS_P12: idx = 4'h7;
      PDR_OFS_P14: idx = 4'h8;
      PDR_OFS_P15: idx = 4'h9;
      default:     idx = PDR_IDX_NONE;
    endcase
    return idx;
  endfunction : pdr_index

endpackage : pdr_pkg

// ===== design/pdr_port_direction.sv
// Functional notes
// - Every implemented direction bit sets its own pin to input or output on its own.
// - Each direction register takes both single-bit writes and whole-byte writes.
// - System reset loads every direction register with all ones, all pins inputs.
// - A zero bit turns the pin's output buffer on, a one bit turns it off.
// - Bit n of the register for port m governs pin n of port m.
// - The larger variant adds a port 8 register at FF28H with only bit 0 active.
module pdr_port_direction
  import pdr_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0
)
(
  input  wire logic                     mclk,        // System clock, 100 MHz
  input  wire logic                     reset,       // Synchronous reset, active high
  input  wire pdr_req_t                 req,         // Processor access, one cycle each
  output logic     [7:0]                rd_data_reg, // Read data
  output logic                          rd_valid_reg,// Read data valid pulse
  output logic     [PDR_NREG-1:0][7:0]  port_dir,    // Direction bits per port
  output logic     [PDR_NREG-1:0][7:0]  port_buf_en  // Output buffer enable per pin
);

  // implemented-bit masks
  // Fixed per variant at elaboration, so masking costs no storage
  localparam logic [PDR_NREG-1:0][7:0] MASKS =
    LARGE_VARIANT ? PDR_MASK_LARGE : PDR_MASK_SMALL;

  logic [3:0]          req_idx;
  logic                req_hit;
  logic [PDR_NREG-1:0] sel;
  logic [7:0]          rd_data_next;

  // Decode; port 8 is absent in the smaller variant
  // port 8 only large
  always_comb
  begin
    req_idx = pdr_index(req.addr);
    req_hit = (req_idx != PDR_IDX_NONE) &&
              (LARGE_VARIANT || (req_idx != PDR_IDX_P8));
  end

  // One register per port, each with its own implemented mask
  genvar gi;
  generate
    for (gi = 0; gi < PDR_NREG; gi++)
    begin : g_port
      assign sel[gi] = req_hit && (req_idx == 4'(gi));
      pdr_dir_reg #(
        .IMPL_MASK (MASKS[gi])
      ) u_dir (
        .mclk    (mclk),
        .reset   (reset),
        .sel     (sel[gi]),
        .byte_wr (req.byte_wr),
        .bit_wr  (req.bit_wr),
        .bit_sel (req.bit_sel),
        .bit_val (req.bit_val),
        .wdata   (req.wdata),
        .dir_reg (port_dir[gi]),
        .buf_reg (port_buf_en[gi])
      );

      // unimplemented bits stay one on every port
      property p_port_unimpl;
        @(posedge mclk) disable iff (reset)
        (port_dir[gi] & ~MASKS[gi]) == ~MASKS[gi];
      endproperty
      a_port_unimpl: assert property (p_port_unimpl)
        else $error("unimplemented direction bit cleared");
    end
  endgenerate

  // Read mux; unmapped reads return all ones like an empty register
  always_comb
  begin
    rd_data_next = PDR_UNMAPPED;
    if (req_hit)
    begin
      rd_data_next = port_dir[req_idx];
    end
  end

  // read data register
  // Held between reads so software may pick it up late
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rd_data_reg <= PDR_RESET_VAL;
    end
    else if (req.rd)
    begin
      rd_data_reg <= rd_data_next;
    end
  end

  // Read valid, one cycle after the request
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      rd_valid_reg <= req.rd;
    end
  end

  // Helper state for the checks below; no reset, only read after a request
  logic [3:0]               past_idx;
  logic                     past_hit;
  logic [PDR_NREG-1:0][7:0] past_dir;
  always_ff @(posedge mclk)
  begin
    past_idx <= req_idx;
    past_hit <= req_hit;
    past_dir <= port_dir;
  end

  property p_reset_ones;
    @(posedge mclk) reset |=> (port_dir == {PDR_NREG{PDR_RESET_VAL}});
  endproperty
  a_reset_ones: assert property (p_reset_ones)
    else $error("direction registers not all ones after reset");

  sequence s_byte_wr;
    req.byte_wr && !req.bit_wr && req_hit;
  endsequence

  // byte write lands with unimplemented bits high
  property p_byte_write;
    @(posedge mclk) disable iff (reset)
    s_byte_wr |=> port_dir[past_idx] == ($past(req.wdata) | ~MASKS[past_idx]);
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("byte write not stored");

  sequence s_bit_wr;
    req.bit_wr && !req.byte_wr && req_hit;
  endsequence

  // bit write changes the chosen bit only
  property p_bit_write;
    logic [2:0] b;
    logic [7:0] old;
    @(posedge mclk) disable iff (reset)
    (s_bit_wr, b = req.bit_sel, old = port_dir[req_idx]) |=>
      (port_dir[past_idx][b] == ($past(req.bit_val) | ~MASKS[past_idx][b])) &&
      (((port_dir[past_idx] ^ old) & ~(8'h01 << b)) == 8'h00);
  endproperty
  a_bit_write: assert property (p_bit_write)
    else $error("bit write disturbed other bits");

  // buffer enable is the inverse of direction
  property p_buf_polarity;
    @(posedge mclk) disable iff (reset)
    ##1 (port_buf_en == ~port_dir);
  endproperty
  a_buf_polarity: assert property (p_buf_polarity)
    else $error("output buffer enable does not follow direction");

  // a write touches only the addressed port
  property p_pin_map;
    @(posedge mclk) disable iff (reset)
    (s_byte_wr or s_bit_wr) |=>
      (((port_dir ^ $past(port_dir)) & ~({{(PDR_NREG-1)*8{1'b0}}, 8'hFF}
        << (past_idx * 8))) == '0);
  endproperty
  a_pin_map: assert property (p_pin_map)
    else $error("write reached another port");

  // port 8 keeps bits 7..1 high; absent entirely when small
  property p_port8;
    @(posedge mclk) disable iff (reset)
    LARGE_VARIANT ? (port_dir[PDR_IDX_P8][7:1] == 7'h7F)
                  : (port_dir[PDR_IDX_P8] == PDR_RESET_VAL);
  endproperty
  a_port8: assert property (p_port8)
    else $error("port 8 direction holds illegal bits");

  property p_unimpl_ones;
    @(posedge mclk) disable iff (reset)
    (s_byte_wr and (req.wdata == 8'h00)) |=>
      ((port_dir[past_idx] & ~MASKS[past_idx]) == ~MASKS[past_idx]);
  endproperty
  a_unimpl_ones: assert property (p_unimpl_ones)
    else $error("unimplemented bit cleared");

  // read returns the stored byte one cycle later
  property p_read_back;
    @(posedge mclk) disable iff (reset)
    (req.rd && !req.byte_wr && !req.bit_wr) |=> rd_valid_reg &&
      (rd_data_reg == (past_hit ? port_dir[past_idx] : PDR_UNMAPPED));
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read data mismatch");

  // read side and buffers after reset
  property p_reset_outputs;
    @(posedge mclk)
    reset |=> !rd_valid_reg && (rd_data_reg == PDR_RESET_VAL) &&
      (port_buf_en == {PDR_NREG{~PDR_RESET_VAL}});
  endproperty
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("read port or buffer enables not cleared by reset");

  // Any read request
  sequence s_rd;
    req.rd;
  endsequence

  // every read is answered next cycle
  property p_rd_valid;
    @(posedge mclk) disable iff (reset)
    s_rd |=> rd_valid_reg;
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read request not answered");

  // Cycle without a read request
  sequence s_no_rd;
    !req.rd;
  endsequence

  // valid is a single pulse per read
  property p_rd_pulse;
    @(posedge mclk) disable iff (reset)
    s_no_rd |=> !rd_valid_reg;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read valid without a read request");

  // read data stands until the next read
  property p_rd_hold;
    @(posedge mclk) disable iff (reset)
    s_no_rd |=> $stable(rd_data_reg);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");

  // Cycle without any write request
  sequence s_no_wr;
    !req.byte_wr && !req.bit_wr;
  endsequence

  // direction bits and pins hold without a write
  property p_idle_hold;
    @(posedge mclk) disable iff (reset)
    s_no_wr |=> $stable(port_dir) && $stable(port_buf_en);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("direction changed without a write");

  // Write to an address with no register behind it
  sequence s_miss_wr;
    (req.byte_wr || req.bit_wr) && !req_hit;
  endsequence

  // writes to an absent register are dropped
  property p_miss_wr;
    @(posedge mclk) disable iff (reset)
    s_miss_wr |=> $stable(port_dir);
  endproperty
  a_miss_wr: assert property (p_miss_wr)
    else $error("write to an absent register changed a port");

  // Byte and bit write raised together
  sequence s_both_wr;
    req.byte_wr && req.bit_wr && req_hit;
  endsequence

  // byte write wins over a bit write in the same cycle
  property p_byte_priority;
    @(posedge mclk) disable iff (reset)
    s_both_wr |=> port_dir[past_idx] == ($past(req.wdata) | ~MASKS[past_idx]);
  endproperty
  a_byte_priority: assert property (p_byte_priority)
    else $error("bit write overrode a byte write");

  // Read beside a write in one cycle
  sequence s_rd_wr;
    req.rd && (req.byte_wr || req.bit_wr);
  endsequence

  // a read beside a write returns the old value
  // Catches a read mux that looks past the register to its next value
  property p_read_old;
    @(posedge mclk) disable iff (reset)
    s_rd_wr |=> rd_valid_reg &&
      (rd_data_reg == (past_hit ? past_dir[past_idx] : PDR_UNMAPPED));
  endproperty
  a_read_old: assert property (p_read_old)
    else $error("read beside a write did not return the old value");

  // Read of an address with no register behind it
  sequence s_rd_miss;
    req.rd && !req_hit;
  endsequence

  // reads of an absent register return all ones
  property p_rd_miss;
    @(posedge mclk) disable iff (reset)
    s_rd_miss |=> rd_valid_reg && (rd_data_reg == PDR_UNMAPPED);
  endproperty
  a_rd_miss: assert property (p_rd_miss)
    else $error("absent register read not all ones");

endmodule : pdr_port_direction

// ===== verification/pdr_port_direction_test.sv
module pdr_port_direction_test
  import pdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    mclk;
  logic                    reset;
  pdr_req_t                req;
  logic [7:0]              rd_l, rd_s;
  logic                    vl, vs;
  logic [PDR_NREG-1:0][7:0] dir_l, dir_s, buf_l, buf_s;
  int                      errors, checks;
  logic [15:0]             ofs [PDR_NREG] = '{PDR_OFS_P1, PDR_OFS_P2, PDR_OFS_P3, PDR_OFS_P4,
    PDR_OFS_P8, PDR_OFS_P10, PDR_OFS_P11, PDR_OFS_P12, PDR_OFS_P14, PDR_OFS_P15};

  // Larger variant under test, smaller one on the same requests
  pdr_port_direction #(.LARGE_VARIANT(1'b1)) dut (.mclk(mclk), .reset(reset), .req(req),
    .rd_data_reg(rd_l), .rd_valid_reg(vl), .port_dir(dir_l), .port_buf_en(buf_l));
  pdr_port_direction #(.LARGE_VARIANT(1'b0)) dut_small (.mclk(mclk), .reset(reset),
    .req(req), .rd_data_reg(rd_s), .rd_valid_reg(vs), .port_dir(dir_s), .port_buf_en(buf_s));

  // Clock, 100 MHz
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Unimplemented bits always read as one
  function automatic logic [7:0] exp_dir(input int i, input logic big, input logic [7:0] v);
    return v | ~(big ? PDR_MASK_LARGE[i] : PDR_MASK_SMALL[i]);
  endfunction : exp_dir

  // One request, driven on the falling edge, held for one rising edge
  task automatic access(input logic rd, input logic bw, input logic tw, input logic [2:0] bs,
                        input logic bv, input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    req = '{rd, bw, tw, bs, bv, a, d};
    @(negedge mclk);
    req = '0;
  endtask : access

  task automatic check_regs(input logic [PDR_NREG-1:0][7:0] v);
    for (int i = 0; i < PDR_NREG; i++)
    begin
      chk("dir large", exp_dir(i, 1'b1, v[i]), dir_l[i]);
      chk("buf large", ~exp_dir(i, 1'b1, v[i]), buf_l[i]);
      chk("dir small", exp_dir(i, 1'b0, v[i]), dir_s[i]);
      chk("buf small", ~exp_dir(i, 1'b0, v[i]), buf_s[i]);
    end
  endtask : check_regs

  task automatic read_all(input logic [PDR_NREG-1:0][7:0] v);
    for (int i = 0; i < PDR_NREG; i++)
    begin
      access(1'b1, 1'b0, 1'b0, 3'h0, 1'b0, ofs[i], 8'h00);
      chk("valid", 8'h03, {6'h00, vl, vs});
      chk("rd large", exp_dir(i, 1'b1, v[i]), rd_l);
      chk("rd small", exp_dir(i, 1'b0, v[i]), rd_s);
    end
  endtask : read_all

  task automatic reset_values();
    check_regs('1);
    read_all('1);
  endtask : reset_values

  // Zero writes to unused bits break the software rule on purpose
  task automatic byte_writes();
    for (int i = 0; i < PDR_NREG; i++)
      access(1'b0, 1'b1, 1'b0, 3'h0, 1'b0, ofs[i], 8'h00);
    check_regs('0);
    read_all('0);
    for (int i = 0; i < PDR_NREG; i++)
      access(1'b0, 1'b1, 1'b0, 3'h0, 1'b0, ofs[i], 8'hFF);
    check_regs('1);
  endtask : byte_writes

  task automatic bit_writes();
    logic [PDR_NREG-1:0][7:0] v;
    for (int i = 0; i < PDR_NREG; i++)
      for (int n = 0; n < 8; n++)
      begin
        v = '1;
        v[i][n] = 1'b0;
        access(1'b0, 1'b0, 1'b1, 3'(n), 1'b0, ofs[i], 8'h00);
        check_regs(v);
        access(1'b0, 1'b0, 1'b1, 3'(n), 1'b1, ofs[i], 8'h00);
        check_regs('1);
      end
  endtask : bit_writes

  task automatic unmapped();
    access(1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 16'hFF20, 8'h00);
    access(1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 16'hFF29, 8'h00);
    check_regs('1);
    access(1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 16'hFF30, 8'h00);
    chk("unmapped valid", 8'h03, {6'h00, vl, vs});
    chk("unmapped rd large", PDR_UNMAPPED, rd_l);
    chk("unmapped rd small", PDR_UNMAPPED, rd_s);
  endtask : unmapped

  // Read, byte write and bit write in one cycle on port 2
  task automatic same_cycle();
    access(1'b1, 1'b1, 1'b1, 3'h1, 1'b1, PDR_OFS_P2, 8'h00);
    chk("rd old large", PDR_RESET_VAL, rd_l);
    chk("rd old small", PDR_RESET_VAL, rd_s);
    chk("byte over bit large", exp_dir(1, 1'b1, 8'h00), dir_l[1]);
    chk("byte over bit small", exp_dir(1, 1'b0, 8'h00), dir_s[1]);
  endtask : same_cycle

  // Second reset in mid-run, after every register was cleared
  task automatic mid_reset();
    for (int i = 0; i < PDR_NREG; i++)
      access(1'b0, 1'b1, 1'b0, 3'h0, 1'b0, ofs[i], 8'h00);
    access(1'b1, 1'b0, 1'b0, 3'h0, 1'b0, ofs[0], 8'h00);
    chk("rd before reset", exp_dir(0, 1'b1, 8'h00), rd_l);
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    check_regs('1);
    chk("rd after reset", PDR_RESET_VAL, rd_l);
    chk("valid after reset", 8'h00, {6'h00, vl, vs});
  endtask : mid_reset

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial
  begin
    errors = 0;
    checks = 0;
    req    = '0;
    reset  = 1'b1;
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    reset_values();
    byte_writes();
    bit_writes();
    unmapped();
    same_cycle();
    mid_reset();
    print_verdict();
  end

  // Hang guard
  initial
  begin
    #200000;
    errors++;
    print_verdict();
  end

endmodule : pdr_port_direction_test
